// [core/bpf_framer.sv]
// Bus capture PCM framer: word packing, framing, check and serial out
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module bpf_framer #(
  parameter int BIT_DIV = 10
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  // Capture side
  input wire bpf_pkg::bpf_cap_s cap_word_in,
  input wire logic cap_valid_in,
  output logic cap_ready_out,
  input wire logic cap_ovf_in,
  input wire logic [3:0] cap_ovf_gid_in,
  input wire bpf_pkg::bpf_time_s time_in,
  // Serial output
  output logic ser_bit_out,
  output logic ser_stb_out,
  output logic ser_frame_out
);

  initial begin
    if (BIT_DIV < 2 || BIT_DIV > 65535) begin
      $error("BIT_DIV must lie in 2..65535");
    end
  end

  logic [5:0] ctrl_q;
  logic [8:0] len_q;
  logic [7:0] crcl_q;
  logic [7:0] fill_q;
  logic [15:0] timl_q;
  logic [15:0] fcnt_q;
  logic [15:0] ocnt_q;
  logic [15:0] div_q;
  logic tick_q;
  logic [23:0] sh_q;
  logic [4:0] bcnt_q;
  logic wv_q;
  logic cur_crc_q;
  logic first_q;
  logic [8:0] widx_q;
  logic [15:0] crc_q;
  bpf_pkg::bpf_time_s snap_q;
  bpf_pkg::bpf_cap_s hold_q;
  logic hold_v_q;
  logic ovf_pend_q;
  logic [3:0] ovf_gid_q;
  bpf_pkg::bpf_kind_e kind;
  logic [23:0] wrd_d;
  logic fetch;
  logic last;
  logic load;
  logic take;
  logic par_en;

  assign par_en = ctrl_q[bpf_pkg::CTL_PAR];

  // Builds a word: bit 1 is odd parity or the high identifier bit
  function automatic logic [23:0] mk_word(input logic [3:0] gid,
                                          input logic [3:0] lab,
                                          input logic [15:0] info,
                                          input logic par);
    logic [22:0] rest;
    bpf_pkg::bpf_word_s w;
    rest = {gid[2:0], lab, info};
    w = {1'b0, rest};
    w.b1 = par ? ~^rest : gid[3];
    return w;
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic b);
    logic fb;
    fb = c[15] ^ b;
    return {c[14:0], 1'b0} ^ (fb ? bpf_pkg::CRC_POLY : 16'h0000);
  endfunction

  // Register writes
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_q <= bpf_pkg::CTRL_RST;
      len_q <= bpf_pkg::FRAME_DEF;
      crcl_q <= bpf_pkg::CRCL_RST;
      fill_q <= bpf_pkg::FILL_RST;
      timl_q <= bpf_pkg::TIML_RST;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        bpf_pkg::REG_CTRL: ctrl_q <= reg_wdata_in[5:0];
        bpf_pkg::REG_FLEN: begin
          // Out-of-range lengths are ignored
          if (reg_wdata_in >= 16'(bpf_pkg::FRAME_MIN) &&
              reg_wdata_in <= 16'(bpf_pkg::FRAME_MAX)) begin
            len_q <= reg_wdata_in[8:0];
          end
        end
        bpf_pkg::REG_CRCL: crcl_q <= reg_wdata_in[7:0];
        bpf_pkg::REG_FILL: fill_q <= reg_wdata_in[7:0];
        bpf_pkg::REG_TIML: timl_q <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // Register reads, answered one cycle later
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        bpf_pkg::REG_CTRL: reg_rdata_out <= {10'h000, ctrl_q};
        bpf_pkg::REG_FLEN: reg_rdata_out <= {7'h00, len_q};
        bpf_pkg::REG_CRCL: reg_rdata_out <= {8'h00, crcl_q};
        bpf_pkg::REG_FILL: reg_rdata_out <= {8'h00, fill_q};
        bpf_pkg::REG_TIML: reg_rdata_out <= timl_q;
        bpf_pkg::REG_STAT: reg_rdata_out <= {ovf_pend_q, hold_v_q, wv_q,
                                             ctrl_q[bpf_pkg::CTL_EN],
                                             3'h0, widx_q};
        bpf_pkg::REG_FCNT: reg_rdata_out <= fcnt_q;
        bpf_pkg::REG_OCNT: reg_rdata_out <= ocnt_q;
        default: reg_rdata_out <= 16'h0000;
      endcase
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

  // Fixed bit rate divider
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (div_q == 16'(BIT_DIV - 1)) begin
      div_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      div_q <= 16'(div_q + 16'h0001);
      tick_q <= 1'b0;
    end
  end

  // Chooses the next word when enabled and the shifter is empty, outside tick cycles
  assign last = widx_q >= 9'(len_q - 9'h001);
  assign fetch = ctrl_q[bpf_pkg::CTL_EN] && !wv_q && !tick_q;

  always_comb begin
    kind = bpf_pkg::K_NONE;
    if (widx_q == 9'h000) begin
      kind = bpf_pkg::K_SYNC;
    end else if (ctrl_q[bpf_pkg::CTL_TIME] &&
                 widx_q <= 9'(bpf_pkg::TIME_WORDS)) begin
      case (widx_q[1:0])
        2'h1: kind = bpf_pkg::K_THI;
        2'h2: kind = bpf_pkg::K_TLO;
        default: kind = bpf_pkg::K_TUS;
      endcase
    end else if (last && ctrl_q[bpf_pkg::CTL_CRC]) begin
      kind = bpf_pkg::K_CRC;
    end else if (ovf_pend_q) begin
      kind = bpf_pkg::K_OVF;
    end else if (hold_v_q) begin
      if (!hold_q.resp) begin
        kind = bpf_pkg::K_DATA;
      end else if (ctrl_q[bpf_pkg::CTL_RESP]) begin
        kind = bpf_pkg::K_RESP;
      end else begin
        kind = bpf_pkg::K_DROP;
      end
    end else if (!ctrl_q[bpf_pkg::CTL_NOFILL]) begin
      kind = bpf_pkg::K_FILL;
    end else begin
      kind = bpf_pkg::K_NONE;
    end
  end

  always_comb begin
    case (kind)
      bpf_pkg::K_SYNC: wrd_d = bpf_pkg::SYNC_WORD;
      bpf_pkg::K_THI: wrd_d = mk_word(fill_q[7:4], timl_q[15:12],
                                      time_in.hi, par_en);
      bpf_pkg::K_TLO: wrd_d = mk_word(fill_q[7:4], timl_q[11:8],
                                      snap_q.lo, par_en);
      bpf_pkg::K_TUS: wrd_d = mk_word(fill_q[7:4], timl_q[7:4],
                                      snap_q.us, par_en);
      bpf_pkg::K_CRC: wrd_d = mk_word(crcl_q[7:4], crcl_q[3:0],
                                      crc_q, par_en);
      bpf_pkg::K_OVF: wrd_d = mk_word(ovf_gid_q, bpf_pkg::OVF_LABEL,
                                      ocnt_q, par_en);
      bpf_pkg::K_DATA: wrd_d = mk_word(hold_q.gid, hold_q.label,
                                       hold_q.info, par_en);
      bpf_pkg::K_RESP: wrd_d = mk_word(hold_q.gid, timl_q[3:0],
                                       hold_q.info, par_en);
      bpf_pkg::K_FILL: wrd_d = mk_word(fill_q[7:4], fill_q[3:0],
                                       bpf_pkg::FILL_INFO, par_en);
      default: wrd_d = 24'h000000;
    endcase
  end

  assign load = fetch && kind != bpf_pkg::K_NONE && kind != bpf_pkg::K_DROP;
  assign take = fetch && (kind == bpf_pkg::K_DATA || kind == bpf_pkg::K_RESP ||
                          kind == bpf_pkg::K_DROP);

  // Holding slot toward the capture buffer
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hold_q <= '0;
      hold_v_q <= 1'b0;
      cap_ready_out <= 1'b0;
    end else if (cap_valid_in && cap_ready_out) begin
      hold_q <= cap_word_in;
      hold_v_q <= 1'b1;
      cap_ready_out <= 1'b0;
    end else if (take) begin
      hold_v_q <= 1'b0;
      cap_ready_out <= 1'b1;
    end else begin
      cap_ready_out <= !hold_v_q;
    end
  end

  // Overflow marker pending; a new overflow wins over the clear
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ovf_pend_q <= 1'b0;
      ovf_gid_q <= 4'h0;
      ocnt_q <= 16'h0000;
    end else if (cap_ovf_in) begin
      ovf_pend_q <= 1'b1;
      ovf_gid_q <= cap_ovf_gid_in;
      ocnt_q <= 16'(ocnt_q + 16'h0001);
    end else if (load && kind == bpf_pkg::K_OVF) begin
      ovf_pend_q <= 1'b0;
    end
  end

  // Word position in the frame and time snapshot
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      widx_q <= 9'h000;
      fcnt_q <= 16'h0000;
      snap_q <= '0;
    end else if (!ctrl_q[bpf_pkg::CTL_EN]) begin
      widx_q <= 9'h000;
    end else if (load) begin
      if (kind == bpf_pkg::K_SYNC) begin
        snap_q <= time_in;
        fcnt_q <= 16'(fcnt_q + 16'h0001);
      end
      widx_q <= last ? 9'h000 : 9'(widx_q + 9'h001);
    end
  end

  // Shifter, most significant bit first
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sh_q <= 24'h000000;
      bcnt_q <= 5'h00;
      wv_q <= 1'b0;
      cur_crc_q <= 1'b0;
      first_q <= 1'b0;
    end else if (load) begin
      sh_q <= wrd_d;
      bcnt_q <= 5'h00;
      wv_q <= 1'b1;
      cur_crc_q <= kind == bpf_pkg::K_CRC;
      first_q <= kind == bpf_pkg::K_SYNC;
    end else if (tick_q && wv_q) begin
      sh_q <= {sh_q[22:0], 1'b0};
      bcnt_q <= 5'(bcnt_q + 5'h01);
      first_q <= 1'b0;
      if (bcnt_q == 5'd23) begin
        wv_q <= 1'b0;
      end
    end
  end

  // Serial pins
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ser_bit_out <= 1'b0;
      ser_stb_out <= 1'b0;
      ser_frame_out <= 1'b0;
    end else begin
      ser_stb_out <= tick_q && wv_q;
      ser_frame_out <= tick_q && wv_q && first_q;
      if (tick_q && wv_q) begin
        ser_bit_out <= sh_q[23];
      end
    end
  end

  // Frame check accumulator
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      crc_q <= bpf_pkg::CRC_INIT;
    end else if (load && kind == bpf_pkg::K_SYNC) begin
      crc_q <= crc_step(bpf_pkg::CRC_INIT, 1'b0) ^ bpf_pkg::CRC_INIT;
    end else if (tick_q && wv_q && !cur_crc_q) begin
      crc_q <= crc_step(crc_q, sh_q[23]);
    end
  end

  default clocking dc @(posedge mclk_in);
  endclocking
  default disable iff (!arst_n_in);

  sync_word_a: assert property (load && widx_q == 9'h000 |=>
    sh_q == bpf_pkg::SYNC_WORD) else $error("frame does not open with sync");
  fill_info_a: assert property (load && kind == bpf_pkg::K_FILL |=>
    sh_q[15:0] == bpf_pkg::FILL_INFO) else $error("fill pattern wrong");
  odd_parity_a: assert property (load && par_en &&
    kind != bpf_pkg::K_SYNC |=> ^sh_q) else $error("parity not odd");
  msb_first_a: assert property (tick_q && wv_q |=>
    ser_stb_out && ser_bit_out == $past(sh_q[23])) else $error("bit order");
  frame_len_a: assert property (widx_q < len_q)
    else $error("word index past frame end");
  check_last_a: assert property (load && last &&
    ctrl_q[bpf_pkg::CTL_CRC] && widx_q > 9'h003 |-> kind == bpf_pkg::K_CRC)
    else $error("check word missing");
  time_follow_a: assert property (load && widx_q == 9'h001 &&
    ctrl_q[bpf_pkg::CTL_TIME] |=> sh_q[15:0] == $past(time_in.hi))
    else $error("high time word not after sync");
  marker_label_a: assert property (load && kind == bpf_pkg::K_OVF |=>
    sh_q[19:16] == bpf_pkg::OVF_LABEL ##0 !ovf_pend_q || $past(cap_ovf_in))
    else $error("overflow marker wrong");
  crc_restart_a: assert property (load && kind == bpf_pkg::K_SYNC |=>
    crc_q == bpf_pkg::CRC_INIT) else $error("check not restarted");
  hold_order_a: assert property (hold_v_q && !take |=>
    hold_v_q && $stable(hold_q)) else $error("held word lost");


  // Field placement of the word that the shifter has just taken
  time_us_a: assert property (load && kind == bpf_pkg::K_TUS |=>
    sh_q[15:0] == $past(snap_q.us)) else $error("microsecond time misplaced");
  data_bits_a: assert property (load && kind == bpf_pkg::K_DATA |=>
    sh_q[22:0] == $past({hold_q.gid[2:0], hold_q.label, hold_q.info}))
    else $error("data bits reordered");
  wide_gid_a: assert property (load && !par_en && kind == bpf_pkg::K_DATA |=>
    sh_q[23] == $past(hold_q.gid[3])) else $error("identifier bit 1 wrong");
  check_word_a: assert property (load && kind == bpf_pkg::K_CRC |=>
    sh_q[15:0] == $past(crc_q)) else $error("check sequence not placed");
  resp_label_a: assert property (load && kind == bpf_pkg::K_RESP |=>
    sh_q[19:16] == $past(timl_q[3:0])) else $error("response label wrong");

  // Stream continuity and handshake
  fill_keep_a: assert property (ctrl_q[bpf_pkg::CTL_EN] &&
    !ctrl_q[bpf_pkg::CTL_NOFILL] && tick_q && wv_q && bcnt_q == 5'd23
    |=> ##[1:3] wv_q) else $error("output gap without fill");
  ovf_wins_a: assert property (cap_ovf_in |=> ovf_pend_q)
    else $error("overflow lost to marker clear");
  ready_free_a: assert property (cap_ready_out |-> !hold_v_q)
    else $error("ready while slot full");
  frame_pulse_a: assert property (ser_frame_out |-> ser_stb_out)
    else $error("frame pulse without bit");

  frame_c: cover property (ser_frame_out);
  fill_c: cover property (load && kind == bpf_pkg::K_FILL);
  crc_c: cover property (load && kind == bpf_pkg::K_CRC);
  ovf_c: cover property (load && kind == bpf_pkg::K_OVF);
  resp_c: cover property (load && kind == bpf_pkg::K_RESP);

endmodule

// [core/bpf_pkg.sv]
// Constants and types for the bus capture PCM framer
// What this block does
// - 24-bit word: parity/id, id, label, information
// - Group identifier is plain binary, zero first
// - Bit 1 is odd parity or identifier bit
// - Without parity identifier grows to four bits
// - One identifier per bus pair or group
// - Every word carries a four-bit content label
// - Captured bits keep original order
// - Fill words carry information pattern AAAA
// - Overflow marker word, label 0000, precedes data
// - Optional check word ends every frame
// - Check uses x16+x15+x2+1
// - Check word bits excluded from check
// - Time values fill bits 9-24 in order
// - Optional response time word like microsecond word
// - Serial output sends bit 1 first
// - Fixed bit rate, fast enough for data
// - Captured words leave in arrival order
// - Fixed frame length, 129 to 511 words
// - Every frame starts with sync FAF320
// - Optional three time words follow sync
// - Without check, last slot holds data
// - Fill words may be suppressed
package bpf_pkg;
  localparam logic [23:0] SYNC_WORD = 24'hfaf320;
  localparam logic [15:0] FILL_INFO = 16'haaaa;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [3:0] OVF_LABEL = 4'h0;
  localparam int FRAME_MIN = 129;
  localparam int FRAME_MAX = 511;
  localparam int TIME_WORDS = 3;
  localparam logic [8:0] FRAME_DEF = 9'h100;
  // Register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_FLEN = 4'h1;
  localparam logic [3:0] REG_CRCL = 4'h2;
  localparam logic [3:0] REG_FILL = 4'h3;
  localparam logic [3:0] REG_TIML = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h5;
  localparam logic [3:0] REG_FCNT = 4'h6;
  localparam logic [3:0] REG_OCNT = 4'h7;
  // Control bit positions
  localparam int CTL_EN = 0;
  localparam int CTL_PAR = 1;
  localparam int CTL_TIME = 2;
  localparam int CTL_CRC = 3;
  localparam int CTL_NOFILL = 4;
  localparam int CTL_RESP = 5;
  // Reset values
  localparam logic [5:0] CTRL_RST = 6'h0e;
  localparam logic [7:0] CRCL_RST = 8'h07;
  localparam logic [7:0] FILL_RST = 8'h01;
  localparam logic [15:0] TIML_RST = 16'h2345;
  typedef struct packed {
    logic b1;
    logic [2:0] gid;
    logic [3:0] label;
    logic [15:0] info;
  } bpf_word_s;
  typedef struct packed {
    logic resp;
    logic [3:0] gid;
    logic [3:0] label;
    logic [15:0] info;
  } bpf_cap_s;
  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
    logic [15:0] us;
  } bpf_time_s;
  typedef enum logic [3:0] {
    K_SYNC = 4'h0, K_THI = 4'h1, K_TLO = 4'h2, K_TUS = 4'h3,
    K_CRC = 4'h4, K_OVF = 4'h5, K_DATA = 4'h6, K_RESP = 4'h7,
    K_FILL = 4'h8, K_DROP = 4'h9, K_NONE = 4'ha
  } bpf_kind_e;
endpackage

// [verif/bpf_rx_model.sv]
// Telemetry receiver model: rebuilds 24-bit words from the serial stream
`timescale 1ns/1ps
module bpf_rx_model (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // Serial input
  input wire logic ser_bit_in,
  input wire logic ser_stb_in,
  input wire logic ser_frame_in,
  // Rebuilt words
  output logic [23:0] word_out,
  output logic word_vld_out,
  output logic first_out
);
  logic [23:0] sr_q;
  logic [4:0] cnt_q;
  logic first_q;
  // Bits before the first frame marker are ignored; a marker always resyncs
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sr_q <= 24'h0;
      cnt_q <= 5'h0;
      first_q <= 1'b0;
      first_out <= 1'b0;
      word_vld_out <= 1'b0;
    end else begin
      word_vld_out <= 1'b0;
      if (ser_stb_in && (ser_frame_in || cnt_q != 5'h0)) begin
        sr_q <= {sr_q[22:0], ser_bit_in};
        cnt_q <= (ser_frame_in || cnt_q == 5'h18) ? 5'h1 : cnt_q + 5'h1;
        word_vld_out <= !ser_frame_in && cnt_q == 5'h17;
        first_q <= ser_frame_in || (first_q && cnt_q != 5'h17);
        first_out <= first_q;
      end
    end
  end
  assign word_out = sr_q;
endmodule

// [verif/tb_bpf_framer.sv]
// Testbench for the bus capture PCM framer with a serial receiver model
`timescale 1ns/1ps
module tb_bpf_framer;
  localparam int BD = 2;
  typedef struct packed {
    logic [23:0] w;
    logic [23:0] m;
  } bpf_exp_s;
  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [15:0] reg_wdata_in = 16'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [15:0] reg_rdata_out;
  bpf_pkg::bpf_cap_s cap_word_in = '0;
  logic cap_valid_in = 1'b0;
  logic cap_ready_out;
  logic cap_ovf_in = 1'b0;
  logic [3:0] cap_ovf_gid_in = 4'h0;
  bpf_pkg::bpf_time_s time_in = {16'h1357, 16'h2468, 16'h0f1e};
  logic ser_bit_out, ser_stb_out, ser_frame_out, rx_vld, rx_first, rd_pend;
  logic [23:0] rx_word, fillw;
  bpf_exp_s dq[$];
  bpf_exp_s e;
  logic [15:0] rq[$];
  logic [15:0] crc, tw;
  logic par_on = 1'b0;
  logic time_on = 1'b0;
  logic crc_on = 1'b0;
  logic chk = 1'b0;
  int fails = 0;
  int compares = 0;
  int flen, idx, since, nfill, n;

  initial forever #2 mclk_in = ~mclk_in;

  bpf_framer #(.BIT_DIV(BD)) bpf_framer_i (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .cap_word_in(cap_word_in),
    .cap_valid_in(cap_valid_in), .cap_ready_out(cap_ready_out), .cap_ovf_in(cap_ovf_in),
    .cap_ovf_gid_in(cap_ovf_gid_in), .time_in(time_in), .ser_bit_out(ser_bit_out),
    .ser_stb_out(ser_stb_out), .ser_frame_out(ser_frame_out));
  bpf_rx_model bpf_rx_model_i (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .ser_bit_in(ser_bit_out), .ser_stb_in(ser_stb_out), .ser_frame_in(ser_frame_out),
    .word_out(rx_word), .word_vld_out(rx_vld), .first_out(rx_first));

  function automatic logic [23:0] mk(input logic [3:0] g, input logic [3:0] l,
                                     input logic [15:0] i);
    return {par_on ? ~^{g[2:0], l, i} : g[3], g[2:0], l, i};
  endfunction
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [23:0] w);
    for (int k = 23; k >= 0; k--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ w[k]) ? bpf_pkg::CRC_POLY : 16'h0000);
    end
    return c;
  endfunction
  task automatic cmp_word(input logic [23:0] got, input logic [23:0] exp, input logic [23:0] m);
    compares++;
    if ((got & m) !== (exp & m)) begin
      fails++;
      $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] x);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    rq.push_back(x);
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic send(input bpf_pkg::bpf_cap_s c, input logic [23:0] x);
    int k = 0;
    cap_word_in <= c;
    cap_valid_in <= 1'b1;
    @(posedge mclk_in);
    while (cap_ready_out !== 1'b1 && k < 5000) begin
      k++;
      @(posedge mclk_in);
    end
    dq.push_back(bpf_exp_s'{x, 24'hffffff});
    cap_valid_in <= 1'b0;
    repeat (24 * BD) @(posedge mclk_in);
  endtask
  task automatic burst(input int cnt, input logic resp);
    bpf_pkg::bpf_cap_s c;
    for (int k = 0; k < cnt; k++) begin
      c = 25'($urandom);
      c.resp = resp;
      if (c.info == bpf_pkg::FILL_INFO) c.info = 16'h5555;
      send(c, mk(c.gid, resp ? bpf_pkg::TIML_RST[3:0] : c.label, c.info));
    end
  endtask
  task automatic do_reset(input logic [5:0] ctrl, input logic [15:0] fl);
    arst_n_in <= 1'b0;
    repeat (20) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    @(posedge mclk_in);
    dq.delete();
    par_on = ctrl[1];
    time_on = ctrl[2];
    crc_on = ctrl[3];
    chk = !ctrl[4];
    flen = fl;
    wr(bpf_pkg::REG_FLEN, fl);
    rd(bpf_pkg::REG_FLEN, fl);
    wr(bpf_pkg::REG_CTRL, {10'h0, ctrl});
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge mclk_in) begin
    if (rd_pend === 1'b1) cmp_reg(reg_rdata_out, rq.pop_front());
    rd_pend = reg_rd_in;
  end

  // Word watcher: classifies each rebuilt word by its slot in the frame
  always @(posedge mclk_in) begin
    fillw = mk(bpf_pkg::FILL_RST[7:4], bpf_pkg::FILL_RST[3:0], bpf_pkg::FILL_INFO);
    if (!arst_n_in) begin
      idx = 0;
      since = 0;
      nfill = 0;
    end else begin
      if (ser_stb_out === 1'b1) begin
        if (chk && since != 0) cmp_reg(16'(since), 16'(BD));
        since = 1;
      end else if (since != 0) since++;
      if (rx_vld === 1'b1) begin
        tw = idx == 1 ? time_in.hi : idx == 2 ? time_in.lo : time_in.us;
        if (rx_first === 1'b1) begin
          if (chk && idx != 0) cmp_reg(16'(idx), 16'(flen));
          cmp_word(rx_word, bpf_pkg::SYNC_WORD, 24'hffffff);
          idx = 0;
          crc = bpf_pkg::CRC_INIT;
        end else if (time_on && idx >= 1 && idx <= 3) begin
          cmp_word(rx_word, mk(bpf_pkg::FILL_RST[7:4], bpf_pkg::TIML_RST[(4 - idx) * 4 +: 4],
                   tw), 24'hffffff);
        end else if (crc_on && idx == flen - 1) begin
          cmp_word(rx_word, mk(bpf_pkg::CRCL_RST[7:4], bpf_pkg::CRCL_RST[3:0], crc),
                   24'hffffff);
        end else if (rx_word === fillw) begin
          nfill++;
        end else if (dq.size() == 0) begin
          cmp_word(rx_word, fillw, 24'hffffff);
        end else begin
          e = dq.pop_front();
          cmp_word(rx_word, e.w, e.m);
        end
        crc = crc_upd(crc, rx_word);
        idx++;
      end
    end
  end

  initial begin
    #400000;
    fails++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(76928));
    repeat (20) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    @(posedge mclk_in);
    rd(bpf_pkg::REG_CTRL, {10'h0, bpf_pkg::CTRL_RST});
    rd(bpf_pkg::REG_FLEN, {7'h0, bpf_pkg::FRAME_DEF});
    rd(bpf_pkg::REG_CRCL, {8'h0, bpf_pkg::CRCL_RST});
    rd(bpf_pkg::REG_FILL, {8'h0, bpf_pkg::FILL_RST});
    rd(bpf_pkg::REG_TIML, bpf_pkg::TIML_RST);
    rd(4'h8, 16'h0000);
    wr(bpf_pkg::REG_FLEN, 16'h0080);
    wr(bpf_pkg::REG_FLEN, 16'h0200);
    rd(bpf_pkg::REG_FLEN, {7'h0, bpf_pkg::FRAME_DEF});
    // Parity, frame time, check word and response words, shortest frame
    do_reset(6'h2f, 16'd129);
    burst(6, 1'b0);
    // Let the last held word leave first, or the marker would overtake it
    while (cap_ready_out !== 1'b1) @(posedge mclk_in);
    cap_ovf_gid_in <= 4'h5;
    cap_ovf_in <= 1'b1;
    dq.push_back(bpf_exp_s'{mk(4'h5, bpf_pkg::OVF_LABEL, 16'h0), 24'h7f0000});
    @(posedge mclk_in);
    cap_ovf_in <= 1'b0;
    burst(3, 1'b0);
    burst(1, 1'b1);
    repeat (3 * 129 * 24 * BD) @(posedge mclk_in);
    cmp_reg(16'(dq.size()), 16'h0);
    cmp_reg(16'(nfill != 0), 16'h1);
    // Four-bit identifiers, no time words, no check word, longest frame
    do_reset(6'h01, 16'd511);
    burst(8, 1'b0);
    repeat (512 * 24 * BD + 200) @(posedge mclk_in);
    cmp_reg(16'(dq.size()), 16'h0);
    // Fill suppressed: output stops once data runs out
    do_reset(6'h11, 16'd129);
    burst(2, 1'b0);
    // Response word with response words disabled is dropped, never sent
    burst(1, 1'b1);
    void'(dq.pop_back());
    repeat (96 * BD) @(posedge mclk_in);
    n = 0;
    repeat (200) begin
      @(posedge mclk_in);
      if (ser_stb_out !== 1'b0) n++;
    end
    cmp_reg(16'(n), 16'h0);
    cmp_reg(16'(nfill + dq.size()), 16'h0);
    tally_and_finish();
  end
endmodule
